// ==== design/lcm_mode_ctrl.sv ====
// lifecycle mode controller: boot evaluation, monitor command gating, erase-and-return sequence
//
// Contract
// - mode lives in config bytes; monitor command only
// - delivered in development, factory test locked forever
// - factory test first; test and configuration only there
// - development: monitor port fully works, incl. download
// - development: debug command raises software break
// - break holds until resume command or reset; code also drops it once mode leaves development
// - protected refuses memory access, disables debug
// - return command: erase first, then development
// - tampered while return sequence runs
// - failed return from protected ends tampered
// - tampered accepts return; failure stays tampered
// - reset or wake-up runs cold boot
// - boot evaluates mode, applies flags, warm vector
// - boot leaves wake-up source bits untouched
// - monitor port is two-wire clock and data
// - programming in whole 64-byte blocks
// - 16-bit monitor, watches, breakpoints, single step
// - monitor features mostly development-only
// - development: watchdog overflow gives nmi, not reset
module lcm_mode_ctrl
  import lcm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_monitor_serial_clock,
  input wire logic i_monitor_serial_data,
  output logic o_cfg_rd,
  input wire logic i_cfg_rd_valid,
  input wire lcm_cfg_type i_cfg_rd_data,
  output logic o_cfg_wr_valid,
  output lcm_cfg_type o_cfg_wr_data,
  input wire logic i_cfg_wr_done,
  output logic o_erase_req,
  input wire logic i_erase_done,
  input wire logic i_erase_ok,
  input wire logic i_sw_wr_req,
  input wire logic i_sw_wr_cfg_area,
  output logic o_sw_wr_grant,
  input wire logic i_wdt_overflow,
  output logic o_wdt_nmi,
  output logic o_wdt_reset,
  output lcm_mode_type o_mode,
  output logic o_boot_busy,
  output logic o_warm_boot,
  output logic o_wake_src_hold,
  output logic o_test_en,
  output logic o_debug_en,
  output logic o_break_halt,
  output logic o_mon_rd_req,
  output logic o_mon_refused,
  output logic o_dl_valid,
  output logic [7:0] o_dl_data,
  output logic o_dl_block_end
);

  typedef enum logic [2:0] {
    ST_BOOT_REQ = 3'b000,
    ST_BOOT_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_WR_WAIT = 3'b011,
    ST_MARK_WAIT = 3'b100,
    ST_ERASE_WAIT = 3'b101,
    ST_DEV_WAIT = 3'b110
  } lcm_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // monitor pins

  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic cmd_valid;
  logic [7:0] cmd_byte;

  lcm_pin_sync #(.WIDTH(2)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_monitor_serial_data, i_monitor_serial_clock}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // data is taken on the rising edge of the monitor clock
  lcm_cmd_shift #(.BITS(CMD_BITS), .IDLE_CYC(IDLE_TIMEOUT_CYC)) u_shift (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_bit_stb(pin_rise[0]),
    .i_bit(pin_level[1]),
    .o_byte_valid(cmd_valid),
    .o_byte(cmd_byte)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  lcm_state_type state_q;
  lcm_mode_type mode_q;
  logic [6:0] dl_left_q;
  logic in_download;
  logic run_cmd;
  logic is_dev;

  assign is_dev = (mode_q == MODE_DEV);
  assign in_download = (dl_left_q != 7'h00);
  // commands are only looked at once boot has settled the mode
  assign run_cmd = cmd_valid && (state_q == ST_RUN) && !in_download;

  //////////////////////////////////////////////////////////////////////////////
  // boot and mode sequencing

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_BOOT_REQ;
      mode_q <= MODE_PROT;
      o_cfg_wr_data <= '{lock: LOCK_SET, mode: CFG_PROT};
      o_warm_boot <= 1'b0;
    end else begin
      o_warm_boot <= 1'b0;
      unique case (state_q)
        ST_BOOT_REQ: begin
          state_q <= ST_BOOT_WAIT;
        end
        ST_BOOT_WAIT: begin
          if (i_cfg_rd_valid) begin
            mode_q <= cfg_decode(i_cfg_rd_data);
            o_warm_boot <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (run_cmd) begin
            unique case (cmd_byte)
              CMD_FACTORY_DONE: begin
                if (mode_q == MODE_FACTORY) begin
                  // locking makes the erased pattern decode as protected
                  o_cfg_wr_data <= '{lock: LOCK_SET, mode: CFG_DEV};
                  state_q <= ST_WR_WAIT;
                end
              end
              CMD_SET_PROT: begin
                if (is_dev) begin
                  mode_q <= MODE_PROT;
                  o_cfg_wr_data <= '{lock: LOCK_SET, mode: CFG_PROT};
                  state_q <= ST_WR_WAIT;
                end
              end
              CMD_RETURN_DEV: begin
                if (mode_q == MODE_PROT || mode_q == MODE_TAMP) begin
                  mode_q <= MODE_TAMP;
                  o_cfg_wr_data <= '{lock: LOCK_SET, mode: CFG_TAMP};
                  state_q <= ST_MARK_WAIT;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_WR_WAIT: begin
          if (i_cfg_wr_done) begin
            mode_q <= cfg_decode(o_cfg_wr_data);
            state_q <= ST_RUN;
          end
        end
        ST_MARK_WAIT: begin
          if (i_cfg_wr_done) begin
            state_q <= ST_ERASE_WAIT;
          end
        end
        ST_ERASE_WAIT: begin
          if (i_erase_done) begin
            if (i_erase_ok) begin
              o_cfg_wr_data <= '{lock: LOCK_SET, mode: CFG_DEV};
              state_q <= ST_DEV_WAIT;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_DEV_WAIT: begin
          if (i_cfg_wr_done) begin
            mode_q <= MODE_DEV;
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_BOOT_REQ;
        end
      endcase
    end
  end

  assign o_cfg_rd = (state_q == ST_BOOT_REQ);
  // config bytes are written only by the command sequences above
  assign o_cfg_wr_valid = (state_q == ST_WR_WAIT) || (state_q == ST_MARK_WAIT) || (state_q == ST_DEV_WAIT);
  assign o_erase_req = (state_q == ST_ERASE_WAIT);
  assign o_boot_busy = (state_q == ST_BOOT_REQ) || (state_q == ST_BOOT_WAIT);
  // no write path to the wake-up source bits exists while booting
  assign o_wake_src_hold = o_boot_busy;
  assign o_mode = mode_q;

  //////////////////////////////////////////////////////////////////////////////
  // software access and watchdog routing

  assign o_sw_wr_grant = i_sw_wr_req && !i_sw_wr_cfg_area;
  assign o_wdt_nmi = i_wdt_overflow && is_dev;
  assign o_wdt_reset = i_wdt_overflow && !is_dev;
  assign o_test_en = (mode_q == MODE_FACTORY) && (state_q == ST_RUN);
  // breakpoints, watches and single step of the monitor core hang off this
  assign o_debug_en = is_dev && (state_q == ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // debug break

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_break_halt <= 1'b0;
    end else if (!is_dev) begin
      o_break_halt <= 1'b0;
    end else if (run_cmd && cmd_byte == CMD_BREAK) begin
      o_break_halt <= 1'b1;
    end else if (run_cmd && cmd_byte == CMD_RESUME) begin
      o_break_halt <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory read and block download

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mon_rd_req <= 1'b0;
      o_mon_refused <= 1'b0;
    end else begin
      o_mon_rd_req <= run_cmd && cmd_byte == CMD_MEM_READ && is_dev;
      o_mon_refused <= run_cmd && !is_dev && (cmd_byte == CMD_MEM_READ || cmd_byte == CMD_MEM_WRITE);
    end
  end

  // bytes after a granted write command are data, not commands
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dl_left_q <= 7'h00;
      o_dl_valid <= 1'b0;
      o_dl_data <= 8'h00;
      o_dl_block_end <= 1'b0;
    end else begin
      o_dl_valid <= 1'b0;
      o_dl_block_end <= 1'b0;
      if (run_cmd && cmd_byte == CMD_MEM_WRITE && is_dev) begin
        dl_left_q <= 7'(BLOCK_BYTES);
      end else if (cmd_valid && in_download) begin
        o_dl_valid <= 1'b1;
        o_dl_data <= cmd_byte;
        dl_left_q <= dl_left_q - 7'h01;
        o_dl_block_end <= (dl_left_q == 7'h01);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_read_needs_dev: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_mon_rd_req |-> $past(mode_q) == MODE_DEV)
    else $error("memory read granted outside development mode");

  a_break_from_dev: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_break_halt) |-> $past(mode_q) == MODE_DEV && $past(cmd_byte) == CMD_BREAK)
    else $error("break raised without debug command in development mode");

  a_break_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_break_halt && is_dev && !(run_cmd && cmd_byte == CMD_RESUME)) |=> o_break_halt)
    else $error("break released without resume");

  a_tamper_in_erase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_erase_req || state_q == ST_MARK_WAIT) |-> mode_q == MODE_TAMP)
    else $error("return sequence running outside tampered mode");

  a_erase_fail_tamp: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_erase_req && i_erase_done && !i_erase_ok) |=> (mode_q == MODE_TAMP && state_q == ST_RUN) [*2])
    else $error("failed erase did not settle in tampered mode");

  a_dev_after_erase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($past(mode_q) == MODE_TAMP && mode_q == MODE_DEV) |-> $past(state_q) == ST_DEV_WAIT)
    else $error("development resumed without completed erase");

  a_no_factory_back: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($past(state_q) == ST_RUN && $past(mode_q) != MODE_FACTORY) |-> mode_q != MODE_FACTORY)
    else $error("factory test mode re-entered");

  a_boot_warm: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == ST_BOOT_WAIT && i_cfg_rd_valid) |=> o_warm_boot ##1 !o_warm_boot)
    else $error("warm boot pulse missing after mode evaluation");

  a_cfg_wr_cmd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_cfg_wr_valid) |-> $past(run_cmd) || $past(state_q) == ST_ERASE_WAIT)
    else $error("config write not caused by a monitor command");

  a_block_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run_cmd && cmd_byte == CMD_MEM_WRITE && is_dev) |=> dl_left_q == 7'(BLOCK_BYTES))
    else $error("download block length wrong");

  a_wdt_dev_nmi: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_wdt_overflow |-> (o_wdt_nmi != o_wdt_reset) && (o_wdt_nmi == (o_mode == MODE_DEV)))
    else $error("watchdog overflow misrouted");

endmodule : lcm_mode_ctrl

// ==== design/lcm_pkg.sv ====
// shared types, codes and timing for the lifecycle mode controller
package lcm_pkg;

  typedef enum logic [1:0] {
    MODE_FACTORY = 2'b00,
    MODE_DEV = 2'b01,
    MODE_PROT = 2'b10,
    MODE_TAMP = 2'b11
  } lcm_mode_type;

  // configuration byte codes as stored in embedded program memory
  localparam logic [7:0] CFG_FACTORY = 8'hff;
  localparam logic [7:0] CFG_DEV = 8'h3c;
  localparam logic [7:0] CFG_PROT = 8'ha5;
  localparam logic [7:0] CFG_TAMP = 8'h96;
  localparam logic [7:0] LOCK_SET = 8'h5a;
  localparam logic [7:0] LOCK_OPEN = 8'hff;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] mode;
  } lcm_cfg_type;

  // monitor port command bytes
  localparam logic [7:0] CMD_BREAK = 8'h01;
  localparam logic [7:0] CMD_RESUME = 8'h02;
  localparam logic [7:0] CMD_MEM_READ = 8'h10;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h11;
  localparam logic [7:0] CMD_SET_PROT = 8'h20;
  localparam logic [7:0] CMD_RETURN_DEV = 8'h21;
  localparam logic [7:0] CMD_FACTORY_DONE = 8'h30;

  localparam int CMD_BITS = 8;
  localparam int BLOCK_BYTES = 64;

  localparam int CLK_PERIOD_NS = 8;
  localparam int IDLE_TIMEOUT_NS = 2000;
  // longest time, so round down
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;

  // unknown patterns fall back to the most restrictive mode
  function automatic lcm_mode_type cfg_decode(input lcm_cfg_type cfg);
    lcm_mode_type m;
    m = MODE_PROT;
    unique case (cfg.mode)
      CFG_FACTORY: m = (cfg.lock == LOCK_OPEN) ? MODE_FACTORY : MODE_PROT;
      CFG_DEV: m = MODE_DEV;
      CFG_PROT: m = MODE_PROT;
      CFG_TAMP: m = MODE_TAMP;
      default: m = MODE_PROT;
    endcase
    return m;
  endfunction : cfg_decode

endpackage : lcm_pkg

// ==== design/lcm_pin_sync.sv ====
// two-flop synchroniser with rising edge detect for the monitor pins
module lcm_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  // refused at elaboration: the loop needs one pin at least
  if (WIDTH < 1) begin : g_bad_width
    $error("lcm_pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
          prev_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
      assign o_rise[g] = sync_q[g] & ~prev_q[g];
    end
  endgenerate

  assign o_level = sync_q;

endmodule : lcm_pin_sync

// ==== design/lcm_cmd_shift.sv ====
// serial-to-byte shifter for the monitor data line, msb first
module lcm_cmd_shift
  import lcm_pkg::*;
#(
  parameter int BITS = CMD_BITS,
  parameter int IDLE_CYC = IDLE_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_bit_stb,
  input wire logic i_bit,
  output logic o_byte_valid,
  output logic [BITS-1:0] o_byte
);

  // shift keeps one old bit at least; counters are 5 and 16 bits
  if (BITS < 2 || BITS > 16) begin : g_bad_bits
    $error("lcm_cmd_shift: BITS out of range");
  end
  if (IDLE_CYC < 1 || IDLE_CYC > 65535) begin : g_bad_idle
    $error("lcm_cmd_shift: IDLE_CYC out of range");
  end

  logic [BITS-1:0] shift_q;
  logic [4:0] cnt_q;
  logic [15:0] idle_q;

  // a stalled host loses only its partial byte, framing restarts
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      idle_q <= 16'h0000;
    end else if (i_bit_stb) begin
      idle_q <= 16'h0000;
    end else if (idle_q != 16'(IDLE_CYC)) begin
      idle_q <= idle_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 5'h00;
      shift_q <= '0;
      o_byte_valid <= 1'b0;
      o_byte <= '0;
    end else begin
      o_byte_valid <= 1'b0;
      if (i_bit_stb) begin
        shift_q <= {shift_q[BITS-2:0], i_bit};
        if (cnt_q == 5'(BITS - 1)) begin
          cnt_q <= 5'h00;
          o_byte_valid <= 1'b1;
          o_byte <= {shift_q[BITS-2:0], i_bit};
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end else if (idle_q == 16'(IDLE_CYC)) begin
        cnt_q <= 5'h00;
      end
    end
  end

endmodule : lcm_cmd_shift

// ==== sim/lcm_host_model.sv ====
// monitor port host model: serial clock and data, msb first
module lcm_host_model
  import lcm_pkg::*;
(
  input wire logic i_clk,
  output logic o_monitor_serial_clock,
  output logic o_monitor_serial_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock rests low between frames
  initial begin
    o_monitor_serial_clock = 1'b0;
    o_monitor_serial_data = 1'b1;
  end

  // ten system clocks make the 80 ns bit; data settles while the clock is low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk);
      o_monitor_serial_data <= b[i];
      repeat (3) @(posedge i_clk);
      o_monitor_serial_clock <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_monitor_serial_clock <= 1'b0;
      @(posedge i_clk);
    end
    // released line shows the inverse, never a stale bit
    o_monitor_serial_data <= ~b[0];
  endtask : send_byte

  // download data always goes out as whole blocks
  task automatic send_block(input logic [7:0] seed);
    for (int n = 0; n < BLOCK_BYTES; n++) begin
      send_byte(seed + 8'(n));
    end
  endtask : send_block
endmodule : lcm_host_model

// ==== sim/tb_lcm_mode_ctrl.sv ====
// self-checking bench for the lifecycle mode controller
module tb_lcm_mode_ctrl
  import lcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cfg_rd_valid = 1'b0, i_cfg_wr_done = 1'b0, i_erase_done = 1'b0, i_erase_ok = 1'b0;
  logic i_sw_wr_req = 1'b0, i_sw_wr_cfg_area = 1'b0, i_wdt_overflow = 1'b0;
  lcm_cfg_type i_cfg_rd_data = '0;
  lcm_cfg_type o_cfg_wr_data;
  lcm_cfg_type cfg_mem = '0;
  lcm_mode_type o_mode;
  logic mon_clk, mon_dat, o_cfg_rd, o_cfg_wr_valid, o_erase_req, o_sw_wr_grant, o_wdt_nmi, o_wdt_reset;
  logic o_boot_busy, o_warm_boot, o_wake_src_hold, o_test_en, o_debug_en, o_break_halt;
  logic o_mon_rd_req, o_mon_refused, o_dl_valid, o_dl_block_end;
  logic rd_arm = 1'b0, erase_pass = 1'b1;
  logic [7:0] o_dl_data, dl_last;
  logic [2:0] wr_cnt = '0, er_cnt = '0;
  int miscompares = 0, comparisons = 0;
  int warm_n = 0, rd_n = 0, ref_n = 0, dl_n = 0, end_n = 0, end_ok = 0, er_n = 0;

  always #4 i_clk = ~i_clk;

  lcm_mode_ctrl dut (
    .i_clk, .i_sys_rst, .i_monitor_serial_clock(mon_clk), .i_monitor_serial_data(mon_dat),
    .o_cfg_rd, .i_cfg_rd_valid, .i_cfg_rd_data, .o_cfg_wr_valid, .o_cfg_wr_data, .i_cfg_wr_done,
    .o_erase_req, .i_erase_done, .i_erase_ok, .i_sw_wr_req, .i_sw_wr_cfg_area, .o_sw_wr_grant,
    .i_wdt_overflow, .o_wdt_nmi, .o_wdt_reset, .o_mode, .o_boot_busy, .o_warm_boot, .o_wake_src_hold,
    .o_test_en, .o_debug_en, .o_break_halt, .o_mon_rd_req, .o_mon_refused, .o_dl_valid, .o_dl_data,
    .o_dl_block_end
  );

  lcm_host_model host (
    .i_clk(i_clk),
    .o_monitor_serial_clock(mon_clk),
    .o_monitor_serial_data(mon_dat)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // memory side: config store, slow write and erase, pulse tallies
  always @(posedge i_clk) begin
    i_cfg_rd_valid <= 1'b0;
    i_cfg_rd_data <= ~cfg_mem;
    i_cfg_wr_done <= 1'b0;
    i_erase_done <= 1'b0;
    i_erase_ok <= ~erase_pass;
    wr_cnt <= o_cfg_wr_valid ? wr_cnt + 3'd1 : 3'd0;
    er_cnt <= o_erase_req ? er_cnt + 3'd1 : 3'd0;
    if (i_sys_rst) begin
      rd_arm <= 1'b1;
    end else if (rd_arm && !o_cfg_rd) begin
      rd_arm <= 1'b0;
      i_cfg_rd_valid <= 1'b1;
      i_cfg_rd_data <= cfg_mem;
    end
    if (wr_cnt == 3'd3) begin
      i_cfg_wr_done <= 1'b1;
      cfg_mem <= o_cfg_wr_data;
      wr_cnt <= 3'd0;
    end
    if (er_cnt == 3'd3) begin
      i_erase_done <= 1'b1;
      i_erase_ok <= erase_pass;
      er_cnt <= 3'd0;
      er_n <= er_n + 1;
    end
    if (o_warm_boot) warm_n <= warm_n + 1;
    if (o_mon_rd_req) rd_n <= rd_n + 1;
    if (o_mon_refused) ref_n <= ref_n + 1;
    if (o_dl_valid) begin
      dl_n <= dl_n + 1;
      dl_last <= o_dl_data;
    end
    if (o_dl_block_end && o_dl_valid && dl_n == 63) end_ok <= end_ok + 1;
    if (o_dl_block_end) end_n <= end_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic zero();
    @(negedge i_clk);
    {rd_n, ref_n, dl_n, end_n, end_ok, er_n} = '0;
  endtask : zero

  // erase=1 waits for an erase request, erase=0 for the end of boot
  task automatic wait_until(input bit erase);
    int k;
    for (k = 0; k < 400 && (erase ? o_erase_req : !o_boot_busy) !== 1'b1; k++) @(negedge i_clk);
    if (k >= 400) begin
      miscompares++;
      $display("CHECK FAILED handshake wait: expected 1, seen timeout");
      report_and_stop();
    end
  endtask : wait_until

  task automatic wait_mode(input lcm_mode_type m);
    int k;
    for (k = 0; k < 400 && o_mode !== m; k++) @(negedge i_clk);
    chk("mode reached", 16'(m), 16'(o_mode));
    if (k >= 400) report_and_stop();
  endtask : wait_mode

  // effect lands a few cycles after the last bit
  task automatic send_cmd(input logic [7:0] b);
    host.send_byte(b);
    repeat (12) @(negedge i_clk);
  endtask : send_cmd

  task automatic boot(input lcm_cfg_type c, input lcm_mode_type m);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    cfg_mem <= c;
    repeat (19) @(posedge i_clk);
    @(negedge i_clk);
    chk("wake source hold in boot", 16'h1, 16'(o_wake_src_hold));
    chk("config read in reset", 16'h1, 16'(o_cfg_rd));
    warm_n = 0;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    wait_until(1'b0);
    @(negedge i_clk);
    chk("warm boot pulses", 16'h1, 16'(warm_n));
    chk("mode after boot", 16'(m), 16'(o_mode));
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_factory();
    boot({LOCK_OPEN, CFG_FACTORY}, MODE_FACTORY);
    chk("test enable", 16'h1, 16'(o_test_en));
    zero();
    send_cmd(CMD_MEM_READ);
    chk("refused outside dev", 16'h1, 16'(ref_n));
    send_cmd(CMD_FACTORY_DONE);
    wait_mode(MODE_DEV);
    repeat (8) @(negedge i_clk);
    chk("stored config", {LOCK_SET, CFG_DEV}, cfg_mem);
    boot(cfg_mem, MODE_DEV);
    boot({LOCK_SET, CFG_FACTORY}, MODE_PROT);
    $display("test factory finished");
  endtask : t_factory

  task automatic t_dev();
    boot({LOCK_SET, CFG_DEV}, MODE_DEV);
    chk("debug enable", 16'h1, 16'(o_debug_en));
    chk("test enable in dev", 16'h0, 16'(o_test_en));
    @(posedge i_clk);
    i_sw_wr_req <= 1'b1;
    i_sw_wr_cfg_area <= 1'b1;
    i_wdt_overflow <= 1'b1;
    @(negedge i_clk);
    chk("sw grant config area", 16'h0, 16'(o_sw_wr_grant));
    chk("wdt nmi", 16'h2, 16'({o_wdt_nmi, o_wdt_reset}));
    @(posedge i_clk);
    i_sw_wr_cfg_area <= 1'b0;
    i_wdt_overflow <= 1'b0;
    @(negedge i_clk);
    chk("sw grant other area", 16'h1, 16'(o_sw_wr_grant));
    @(posedge i_clk);
    i_sw_wr_req <= 1'b0;
    zero();
    send_cmd(CMD_MEM_READ);
    chk("reads granted", 16'h1, 16'(rd_n));
    send_cmd(CMD_BREAK);
    chk("break halt", 16'h1, 16'(o_break_halt));
    repeat (300) @(negedge i_clk);
    chk("halt holds", 16'h1, 16'(o_break_halt));
    send_cmd(CMD_RESUME);
    chk("halt after resume", 16'h0, 16'(o_break_halt));
    send_cmd(CMD_MEM_WRITE);
    host.send_block(8'h40);
    repeat (12) @(negedge i_clk);
    chk("download bytes", 16'h0040, 16'(dl_n));
    chk("block ends with 64th", 16'h0101, {8'(end_n), 8'(end_ok)});
    chk("last byte", 16'h007f, 16'(dl_last));
    send_cmd(CMD_BREAK);
    boot({LOCK_SET, CFG_DEV}, MODE_DEV);
    chk("halt after reset", 16'h0, 16'(o_break_halt));
    $display("test development finished");
  endtask : t_dev

  task automatic t_prot();
    send_cmd(CMD_SET_PROT);
    chk("mode at command", 16'(MODE_PROT), 16'(o_mode));
    repeat (8) @(negedge i_clk);
    chk("stored config", {LOCK_SET, CFG_PROT}, cfg_mem);
    chk("debug enable", 16'h0, 16'(o_debug_en));
    zero();
    send_cmd(CMD_MEM_READ);
    send_cmd(CMD_MEM_WRITE);
    send_cmd(CMD_BREAK);
    chk("refusals", 16'h2, 16'(ref_n));
    chk("reads and bytes", 16'h0, 16'(rd_n + dl_n));
    chk("break ignored", 16'h0, 16'(o_break_halt));
    @(posedge i_clk);
    i_wdt_overflow <= 1'b1;
    @(negedge i_clk);
    chk("wdt reset", 16'h2, 16'({o_wdt_reset, o_wdt_nmi}));
    @(posedge i_clk);
    i_wdt_overflow <= 1'b0;
    $display("test protected finished");
  endtask : t_prot

  task automatic t_return();
    erase_pass = 1'b0;
    host.send_byte(CMD_RETURN_DEV);
    wait_until(1'b1);
    chk("mode during erase", 16'(MODE_TAMP), 16'(o_mode));
    repeat (30) @(negedge i_clk);
    chk("mode after failed erase", 16'(MODE_TAMP), 16'(o_mode));
    chk("stored config", {LOCK_SET, CFG_TAMP}, cfg_mem);
    boot(cfg_mem, MODE_TAMP);
    erase_pass = 1'b1;
    zero();
    host.send_byte(CMD_RETURN_DEV);
    wait_until(1'b1);
    chk("mode during retry", 16'(MODE_TAMP), 16'(o_mode));
    wait_mode(MODE_DEV);
    chk("erase before dev", 16'h1, 16'(er_n));
    repeat (8) @(negedge i_clk);
    chk("stored config", {LOCK_SET, CFG_DEV}, cfg_mem);
    $display("test return finished");
  endtask : t_return

  task automatic t_unknown();
    boot({8'h00, 8'h77}, MODE_PROT);
    boot({8'h00, 8'h00}, MODE_PROT);
    chk("debug enable", 16'h0, 16'(o_debug_en));
    $display("test unknown pattern finished");
  endtask : t_unknown

  initial begin
    t_factory();
    t_dev();
    t_prot();
    t_return();
    t_unknown();
    report_and_stop();
  end
endmodule : tb_lcm_mode_ctrl
